// ### bench/prpa_checker.sv
`timescale 1ns/10ps
module prpa_checker (
  // Clock and reset
  input wire        core_clk,
  input wire        rstn,
  // Request
  input wire        req_valid,
  input wire        req_ready,
  input wire [29:0] req_addr,
  input wire        req_write,
  input wire [1:0]  req_master,
  input wire        module_hit,
  // Response and registers
  input wire        resp_valid,
  input wire        resp_err,
  input wire        tgt_valid,
  input wire [7:0]  region0_access_control,
  input wire [7:0]  region1_access_control
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire take = req_valid && req_ready;
  wire is_reg = req_addr[29:1] == 29'h18;
  wire lk = req_addr[0] ? region1_access_control[7] : region0_access_control[7];
  a_resp_pulse: assert property (take |=> resp_valid && !req_ready ##1 !resp_valid)
    else $error("response pulse wrong");
  a_far_region: assert property (take && req_addr[29:27] != 0 && !module_hit |=> resp_err)
    else $error("reserved region not refused");
  a_module_pass: assert property (take && module_hit && !is_reg |=> tgt_valid)
    else $error("module access not forwarded");
  a_reg_local: assert property (take && is_reg |=> !tgt_valid)
    else $error("register access forwarded");
  a_untrusted_wr: assert property (take && is_reg && req_write && req_master == 2'd3 |=> resp_err)
    else $error("untrusted write accepted");
  a_locked_wr: assert property (take && is_reg && req_write && lk |=> resp_err)
    else $error("locked write accepted");
  a_lock0_hold: assert property (region0_access_control[7] |=> $stable(region0_access_control))
    else $error("locked region0 changed");
  a_lock1_hold: assert property (region1_access_control[7] |=> $stable(region1_access_control))
    else $error("locked region1 changed");
  a_err_silent: assert property (resp_err |-> resp_valid && !tgt_valid)
    else $error("error access reached target");
  c_reg_wr: cover property (take && is_reg && req_write);
  c_err: cover property (resp_err);
  c_fwd: cover property (tgt_valid);
endmodule // prpa_checker
bind prpa_access_ctrl prpa_checker chk_u (.core_clk(core_clk), .rstn(rstn),
  .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_write(req_write),
  .req_master(req_master), .module_hit(module_hit), .resp_valid(resp_valid),
  .resp_err(resp_err), .tgt_valid(tgt_valid), .region0_access_control(region0_access_control),
  .region1_access_control(region1_access_control));

// ### bench/prpa_master_model.sv
`timescale 1ns/10ps
module prpa_master_model (
  // Clock
  input  wire         core_clk,
  // Request
  output logic        req_valid = 1'b0,
  input  wire         req_ready,
  output logic [29:0] req_addr = 30'h0,
  output logic        req_write = 1'b0,
  output logic        req_exec = 1'b0,
  output logic        req_super = 1'b0,
  output logic [1:0]  req_master = 2'h0,
  output logic [7:0]  req_wdata = 8'h0,
  // Response
  input  wire         resp_valid,
  input  wire         resp_err,
  input  wire         tgt_valid,
  input  wire [7:0]   resp_rdata
);
  logic [10:0] last;
  // k is {write, exec, super, master}
  task automatic access(input [29:0] a, input [4:0] k, input [7:0] d);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_addr <= a;
    {req_write, req_exec, req_super, req_master} <= k;
    req_wdata <= d & 8'h8f;
    @(posedge core_clk iff req_ready);
    req_valid <= 1'b0;
    // Released lines show no stale value
    req_addr <= ~a;
    req_wdata <= ~d;
    @(posedge core_clk);
    last = {resp_valid, resp_err, tgt_valid, resp_rdata};
  endtask
endmodule // prpa_master_model

// ### bench/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin $display("wrong value %s exp %h got %h", n, e, a); err_count++; end end
module tb_top;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        module_hit = 1'b0;
  logic [2:0]  master_privilege_bits = 3'h7;
  logic [2:0]  trusted_masters = 3'h7;
  wire         req_valid, req_ready, req_write, req_exec, req_super, resp_valid, resp_err, tgt_valid;
  wire [29:0]  req_addr;
  wire [1:0]   req_master;
  wire [7:0]   req_wdata, resp_rdata, region0_access_control, region1_access_control;
  wire [29:0]  tgt_addr;
  wire         tgt_write, tgt_exec;
  wire [7:0]   tgt_wdata;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [5:0]  perm [16] = '{6'h30, 6'h20, 6'h24, 6'h20, 6'h36, 6'h34, 6'h36, 6'h00,
                             6'h38, 6'h28, 6'h2d, 6'h08, 6'h3f, 6'h3d, 6'h34, 6'h39};
  prpa_access_ctrl dut_u (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_write(req_write), .req_exec(req_exec),
    .req_super(req_super), .req_master(req_master), .req_wdata(req_wdata),
    .module_hit(module_hit), .master_privilege_bits(master_privilege_bits),
    .trusted_masters(trusted_masters), .resp_valid(resp_valid), .resp_err(resp_err),
    .resp_rdata(resp_rdata), .tgt_valid(tgt_valid), .tgt_addr(tgt_addr),
    .tgt_write(tgt_write), .tgt_exec(tgt_exec),
    .tgt_wdata(tgt_wdata), .region0_access_control(region0_access_control),
    .region1_access_control(region1_access_control));
  prpa_master_model m_u (.core_clk(core_clk), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_write(req_write), .req_exec(req_exec), .req_super(req_super),
    .req_master(req_master), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_err(resp_err), .tgt_valid(tgt_valid), .resp_rdata(resp_rdata));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Refused accesses are never forwarded; register accesses never are
  task automatic acc(input [29:0] a, input [4:0] k, input [7:0] d, input e, input [7:0] r);
    m_u.access(a, k, d);
    `CHK("response", {1'b1, e, !e && a[29:1] != 29'h18, r}, m_u.last)
    // Forwarded copy holds until the next take
    if (!e && a[29:1] != 29'h18)
      `CHK("target", {a, k[4], k[3], d & 8'h8f}, {tgt_addr, tgt_write, tgt_exec, tgt_wdata})
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    logic [4:0] k;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    `CHK("region0", 8'h00, region0_access_control)
    acc(30'h100, 5'b00100, 8'h00, 1'b0, 8'h00);
    acc(30'h100, 5'b10100, 8'h11, 1'b0, 8'h00);
    acc(30'h100, 5'b00000, 8'h00, 1'b1, 8'h00);
    acc(30'h031, 5'b00100, 8'h00, 1'b0, 8'h00);
    $display("test reset_defaults done");
    for (int c = 0; c < 16; c++) begin
      acc(30'h031, 5'b10100, c[7:0], 1'b0, 8'h00);
      `CHK("region1", c[7:0], region1_access_control)
      for (int i = 0; i < 6; i++) begin
        k = {i % 3 == 1, i % 3 == 2, i < 3, 2'd0};
        acc(30'h07ff_fffa + i, k, 8'h5a, !perm[c][5 - i], 8'h00);
      end
    end
    $display("test codes done");
    master_privilege_bits <= 3'h5;
    acc(30'h0400_0000, 5'b00101, 8'h00, 1'b1, 8'h00);
    acc(30'h0400_0000, 5'b01101, 8'h00, 1'b0, 8'h00);
    acc(30'h0800_0000, 5'b00100, 8'h00, 1'b1, 8'h00);
    acc(30'h3c00_0000, 5'b00100, 8'h00, 1'b1, 8'h00);
    module_hit <= 1'b1;
    acc(30'h100, 5'b00000, 8'h00, 1'b0, 8'h00);
    module_hit <= 1'b0;
    $display("test regions done");
    trusted_masters <= 3'h5;
    acc(30'h030, 5'b10101, 8'h07, 1'b1, 8'h00);
    acc(30'h030, 5'b10111, 8'h07, 1'b1, 8'h00);
    acc(30'h030, 5'b10100, 8'h8c, 1'b0, 8'h00);
    acc(30'h030, 5'b10100, 8'h03, 1'b1, 8'h00);
    acc(30'h030, 5'b10100, 8'h0c, 1'b1, 8'h00);
    acc(30'h030, 5'b00100, 8'h00, 1'b0, 8'h8c);
    acc(30'h100, 5'b00000, 8'h00, 1'b0, 8'h00);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    `CHK("region0", 8'h00, region0_access_control)
    $display("test lock done");
    summarize();
  end
endmodule // tb_top

// ### logic/prpa_access_ctrl.v
`timescale 1ns/10ps
`include "prpa_map.vh"
module prpa_access_ctrl (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Request from internal_peripheral_bus master
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [29:0] req_addr,
  input  wire        req_write,
  input  wire        req_exec,
  input  wire        req_super,
  input  wire [1:0]  req_master,
  input  wire [7:0]  req_wdata,
  // System control inputs
  input  wire        module_hit,
  input  wire [2:0]  master_privilege_bits,
  input  wire [2:0]  trusted_masters,
  // Response to master
  output reg         resp_valid,
  output reg         resp_err,
  output reg  [7:0]  resp_rdata,
  // Forwarded access to target
  output reg         tgt_valid,
  output reg  [29:0] tgt_addr,
  output reg         tgt_write,
  output reg         tgt_exec,
  output reg  [7:0]  tgt_wdata,
  // Register contents
  output wire [7:0]  region0_access_control,
  output wire [7:0]  region1_access_control
);
  reg        state_q;
  reg        state_d;
  wire       accept;
  wire [3:0] region_idx;
  wire       region_impl;
  wire       reg_hit;
  wire       reg_sel;
  wire       eff_super;
  wire       master_trusted;
  wire [7:0] reg_val [0:1];
  wire [1:0] reg_locked;
  wire [3:0] sel_code;
  wire       sup_r;
  wire       sup_w;
  wire       sup_x;
  wire       usr_r;
  wire       usr_w;
  wire       usr_x;
  reg        region_ok;
  reg        reg_err;
  wire       reg_wr_ok;
  wire       access_err;

  // One request in flight; response follows one cycle later
  assign req_ready = (state_q == `PRPA_ST_IDLE);
  assign accept    = req_valid && req_ready;

  always @* begin
    case (state_q)
      `PRPA_ST_IDLE: state_d = accept ? `PRPA_ST_RESP : `PRPA_ST_IDLE;
      `PRPA_ST_RESP: state_d = `PRPA_ST_IDLE;
      default:       state_d = `PRPA_ST_IDLE;
    endcase
  end

  // Region select from offset bits
  assign region_idx  = req_addr[`PRPA_REGION_MSB:`PRPA_REGION_LSB];
  // Regions 2..15 are reserved space with no register
  assign region_impl = (region_idx < `PRPA_NUM_REGIONS);
  assign sel_code    = region_idx[0] ? reg_val[1][`PRPA_CODE_MSB:0]
                                     : reg_val[0][`PRPA_CODE_MSB:0];

  // Master 3 has no privilege bit and is never trusted
  assign eff_super = (req_master != 2'h3) &&
                     master_privilege_bits[req_master] && req_super;
  assign master_trusted = (req_master != 2'h3) && trusted_masters[req_master];

  // Control register window
  assign reg_hit = (req_addr == `PRPA_REG0_OFS) || (req_addr == `PRPA_REG1_OFS);
  assign reg_sel = (req_addr == `PRPA_REG1_OFS);

  prpa_perm_decode u_perm (
    .code  (sel_code),
    .sup_r (sup_r),
    .sup_w (sup_w),
    .sup_x (sup_x),
    .usr_r (usr_r),
    .usr_w (usr_w),
    .usr_x (usr_x)
  );

  always @* begin
    if (!region_impl) begin
      region_ok = 1'b0;
    end else if (req_exec) begin
      region_ok = eff_super ? sup_x : usr_x;
    end else if (req_write) begin
      region_ok = eff_super ? sup_w : usr_w;
    end else begin
      region_ok = eff_super ? sup_r : usr_r;
    end
  end

  // Register accesses: fetch is refused, writes need trust and no lock
  always @* begin
    if (req_exec) begin
      reg_err = 1'b1;
    end else if (req_write) begin
      reg_err = !master_trusted || reg_locked[reg_sel];
    end else begin
      reg_err = 1'b0;
    end
  end

  assign reg_wr_ok = accept && reg_hit && req_write && !reg_err;

  // Module-protected space is judged by the module permission checker
  assign access_err = reg_hit ? reg_err
                              : (!module_hit && !region_ok);

  genvar g;
  generate
    for (g = 0; g < `PRPA_NUM_REGIONS; g = g + 1) begin : g_region
      prpa_region_reg u_reg (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wr_en    (reg_wr_ok && (reg_sel == g)),
        .wr_data  (req_wdata),
        .value    (reg_val[g]),
        .locked   (reg_locked[g])
      );
    end
  endgenerate

  assign region0_access_control = reg_val[0];
  assign region1_access_control = reg_val[1];

  always @(posedge core_clk) begin
    if (!rstn) begin
      state_q    <= `PRPA_ST_IDLE;
      resp_valid <= 1'b0;
      resp_err   <= 1'b0;
      resp_rdata <= 8'h00;
      tgt_valid  <= 1'b0;
      tgt_addr   <= 30'h0000000;
      tgt_write  <= 1'b0;
      tgt_exec   <= 1'b0;
      tgt_wdata  <= 8'h00;
    end else begin
      state_q    <= state_d;
      resp_valid <= accept;
      resp_err   <= accept && access_err;
      resp_rdata <= (accept && reg_hit && !req_write && !req_exec) ?
                    reg_val[reg_sel] : 8'h00;
      // A refused access never reaches the target
      tgt_valid  <= accept && !reg_hit && !access_err;
      if (accept) begin
        tgt_addr  <= req_addr;
        tgt_write <= req_write;
        tgt_exec  <= req_exec;
        tgt_wdata <= req_wdata;
      end
    end
  end
endmodule // prpa_access_ctrl

// ### logic/prpa_map.vh
// Operation
// - Peripheral space splits into sixteen 64-Mbyte regions; only first two have registers.
// - Address bits 29 to 26 pick the region control register for an access.
// - Each region control register is 8 bits with read, write, execute attributes.
// - Modules under module permission registers ignore the first region register; the code ignores both region registers and the reserved regions on module_hit.
// - With lock bit 7 set, writes end in error and leave contents unchanged.
// - Lock stays set once written; only system reset clears it.
// - Bits 3 to 0 are a permission code, separate for supervisor and user.
// - After reset supervisor may read and write; user has no access.
// - Codes 0000-0011: S rw/U none, S r/U none, S r/U r, S r/U none.
// - Codes 0100-0111: both rw, S rw/U r, both rw, none for either.
// - Codes 1000-1011: S rwx/U none, S rx/U none, both rx, S x/U none.
// - Codes 1100-1111: both rwx, S rwx/U rx, S rw/U r, S rwx/U x.
// - Region 0 covers 0x0000_0000-0x03FF_FFFF; region 1 covers 0x0400_0000-0x07FF_FFFF.
// - Per-master privilege bit: clear forces user mode, set uses sourced attribute.
// - Writes to control registers by non-trusted masters abort with error, no change.
`ifndef PRPA_MAP_VH
`define PRPA_MAP_VH
`define PRPA_ADDR_W       30
`define PRPA_REGION_MSB   29
`define PRPA_REGION_LSB   26
`define PRPA_NUM_REGIONS  2
`define PRPA_REG0_OFS     30'h0000030
`define PRPA_REG1_OFS     30'h0000031
`define PRPA_LOCK_BIT     7
`define PRPA_CODE_MSB     3
`define PRPA_REG_RESET    8'h00
`define PRPA_ST_IDLE      1'b0
`define PRPA_ST_RESP      1'b1
`endif

// ### logic/prpa_perm_decode.v
`timescale 1ns/10ps
`include "prpa_map.vh"
module prpa_perm_decode (
  // Permission code
  input  wire [3:0] code,
  // Granted rights
  output reg        sup_r,
  output reg        sup_w,
  output reg        sup_x,
  output reg        usr_r,
  output reg        usr_w,
  output reg        usr_x
);
  // Order: sup r w x, usr r w x
  reg [5:0] rights;

  always @* begin
    case (code)
      4'h0:    rights = 6'b110_000;
      4'h1:    rights = 6'b100_000;
      4'h2:    rights = 6'b100_100;
      4'h3:    rights = 6'b100_000;
      4'h4:    rights = 6'b110_110;
      4'h5:    rights = 6'b110_100;
      4'h6:    rights = 6'b110_110;
      4'h7:    rights = 6'b000_000;
      4'h8:    rights = 6'b111_000;
      4'h9:    rights = 6'b101_000;
      4'ha:    rights = 6'b101_101;
      4'hb:    rights = 6'b001_000;
      4'hc:    rights = 6'b111_111;
      4'hd:    rights = 6'b111_101;
      4'he:    rights = 6'b110_100;
      4'hf:    rights = 6'b111_001;
      default: rights = 6'b000_000;
    endcase
    sup_r = rights[5];
    sup_w = rights[4];
    sup_x = rights[3];
    usr_r = rights[2];
    usr_w = rights[1];
    usr_x = rights[0];
  end
endmodule // prpa_perm_decode

// ### logic/prpa_region_reg.v
`timescale 1ns/10ps
`include "prpa_map.vh"
module prpa_region_reg (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rstn,
  // Write port
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // Contents
  output wire [7:0] value,
  output wire       locked
);
  localparam [7:0] RST_VAL = `PRPA_REG_RESET;

  reg       lock_q;
  reg [3:0] code_q;

  always @(posedge core_clk) begin
    if (!rstn) begin
      lock_q <= RST_VAL[`PRPA_LOCK_BIT];
      code_q <= RST_VAL[`PRPA_CODE_MSB:0];
    end else if (wr_en && !lock_q) begin
      // Lock can only go up; reset is its sole clear
      lock_q <= lock_q | wr_data[`PRPA_LOCK_BIT];
      code_q <= wr_data[`PRPA_CODE_MSB:0];
    end
  end

  // Reserved bits 6:4 are not stored and read zero
  assign value  = {lock_q, 3'h0, code_q};
  assign locked = lock_q;
endmodule // prpa_region_reg
